// *** verilog/fault_recorder_params.svh ***
// Offsets, field positions, reset values and the behaviour list of the global fault recorder
`ifndef FAULT_RECORDER_PARAMS_SVH
`define FAULT_RECORDER_PARAMS_SVH
// Behaviour
// - Config access fault records status, address, first syndrome
// - External fault updates only the status unless it is also a fetch fault
// - Separate Secure and Non-secure status copies
// - First non-external fault on clear status records everything
// - Later fault only sets multiple-fault flag
// - Nested bit marks initial versus stage-2 context
// - Secure fetch check faults non-secure instruction exits
// - Fetch fault goes global without context bank
// - Faulting transaction terminated, reads zero, writes dropped
// - Abort only when matching report enable set
// - Non-secure config interrupt from access fault flag
// - Non-secure global interrupt for other faults
// - Multiple flag raises global, not config interrupt
// - Secure copy drives Secure interrupt pair
// - Untranslated operations still pass stream mapping
// - Unmapped or secure-only access: zero or fault
// - Unimplemented bits read zero, ignore writes
// - Unprivileged access: zero or fault
// - Non-secure touching Secure resource records Secure
// - Secure syndrome holds non-secure origin bit
// - Secure-only global space sends config access faults Secure

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL_NS       12'h000
`define OFS_CTRL_S        12'h004
`define OFS_SCTRL1        12'h008
`define OFS_BANK_NS       12'h010
`define OFS_BANK_S        12'h020
`define OFS_STATUS        12'h000
`define OFS_ADDRESS       12'h004
`define OFS_SYND_FIRST    12'h008
`define OFS_SYND_SECOND   12'h00c

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_INVALID_CTX   0
`define BIT_UNID_STREAM   1
`define BIT_UNIMPL_IRQ    2
`define BIT_UNIMPL_CB     3
`define BIT_PERMISSION    4
`define BIT_CAF           5
`define BIT_EXTERNAL      6
`define BIT_MATCH_CONFL   7
`define BIT_MULTI         31
`define BIT_GLOBAL_FAULT_ABORT_ENABLE          1
`define BIT_GLOBAL_FAULT_IRQ_ENABLE          2
`define BIT_CONFIG_FAULT_ABORT_ENABLE       4
`define BIT_CONFIG_FAULT_IRQ_ENABLE       5
`define BIT_SIF           0
`define BIT_SECURE_ONLY_GLOBAL_SPACE        1
`define CTRL_MASK         32'h0000_0036
`define SCTRL1_MASK       32'h0000_0003
`define STATUS_MASK       32'h8000_00ff
`define RESET_ZERO        32'h0000_0000
`endif

// *** verilog/fault_recorder_pkg.sv ***
// Types shared by the global fault recorder and its bench
package fault_recorder_pkg;
	typedef enum logic [2:0]
	{
		FK_NONE, FK_INVALID_CTX, FK_UNID_STREAM, FK_MATCH_CONFL,
		FK_UNIMPL_CB, FK_UNIMPL_IRQ, FK_EXTERNAL
	} fault_kind_t;

	typedef struct packed
	{
		logic        valid;
		fault_kind_t kind;
		logic        secure;
		logic        nested;
		logic        instr;
		logic        ns_exit;
		logic        ctx_assoc;
		logic        write;
		logic        priv;
		logic [31:0] addr;
		logic [15:0] stream_id;
	} client_txn_t;

	typedef struct packed
	{
		logic        done;
		logic        abort;
		logic        write_dropped;
		logic [31:0] rdata;
	} client_resp_t;

	typedef struct packed
	{
		logic nonsecure_origin_bit;
		logic instr;
		logic write;
		logic nested;
	} syndrome_first_t;

	typedef struct packed
	{
		logic nonsecure_config_fault_irq;
		logic nonsecure_global_fault_irq;
		logic secure_config_fault_irq;
		logic secure_global_fault_irq;
	} irq_t;
endpackage

// *** verilog/global_fault_recorder.sv ***
// Global fault recorder: banked status capture, termination, interrupts, APB config space
`timescale 1ns/1ns
`include "fault_recorder_params.svh"
module global_fault_recorder
#(
	parameter bit SEC_EXT   = 1'b1,
	parameter bit CAF_MODE  = 1'b1,
	parameter bit PRIV_ONLY = 1'b0
)
(
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [2:0]                    pprot,
	output logic                               pready,
	output logic [31:0]                        prdata,
	output logic                               pslverr,
	input  wire fault_recorder_pkg::client_txn_t  client_txn,
	output fault_recorder_pkg::client_resp_t      client_resp,
	output logic                               cb_perm_fault,
	output fault_recorder_pkg::irq_t              irq
);
	// ****************************************************************
	// Register bank signals, index 0 Non-secure, index 1 Secure
	// ****************************************************************
	logic [31:0] status_q  [2];
	logic [31:0] address_q [2];
	logic [31:0] synd0_q   [2];
	logic [31:0] synd1_q   [2];
	logic [31:0] ctrl_q    [2];
	logic [31:0] sctrl1_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic        cb_perm_reg;
	fault_recorder_pkg::client_resp_t resp_reg;
	fault_recorder_pkg::irq_t         irq_reg;

	logic        setup;
	logic        access;
	logic        sec_acc;
	logic        is_secure_reg;
	logic        mapped;
	logic        bad_access;
	logic        cfg_bank;
	logic [31:0] rd_val;
	logic [1:0]  cfg_ev;
	logic [1:0]  cli_ev;
	logic [1:0]  clr_sel;
	logic [1:0]  ctrl_wr;
	logic        sctrl1_wr;
	logic [31:0] cfg_synd0;

	logic        fetch_fault;
	logic        cli_fault;
	logic        cli_global;
	logic        cli_bank;
	logic [31:0] cli_mask;
	logic [31:0] cli_synd0;
	logic        secure_only_global_space;
	logic        secure_fetch_check_enable;

	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign sec_acc = ~pprot[1];
	assign secure_only_global_space  = SEC_EXT & sctrl1_reg[`BIT_SECURE_ONLY_GLOBAL_SPACE];
	assign secure_fetch_check_enable     = SEC_EXT & sctrl1_reg[`BIT_SIF];

	// ****************************************************************
	// Configuration space decode
	// ****************************************************************
	always_comb
	begin
		mapped        = 1'b1;
		is_secure_reg = 1'b0;
		rd_val        = `RESET_ZERO;
		case (paddr)
			`OFS_CTRL_NS:                      rd_val = ctrl_q[0];
			`OFS_CTRL_S:
			begin
				is_secure_reg = 1'b1;
				rd_val        = ctrl_q[1];
			end
			`OFS_SCTRL1:
			begin
				is_secure_reg = 1'b1;
				rd_val        = sctrl1_reg;
			end
			`OFS_BANK_NS + `OFS_STATUS:        rd_val = status_q[0];
			`OFS_BANK_NS + `OFS_ADDRESS:       rd_val = address_q[0];
			`OFS_BANK_NS + `OFS_SYND_FIRST:    rd_val = synd0_q[0];
			`OFS_BANK_NS + `OFS_SYND_SECOND:   rd_val = synd1_q[0];
			`OFS_BANK_S + `OFS_STATUS:
			begin
				is_secure_reg = 1'b1;
				rd_val        = status_q[1];
			end
			`OFS_BANK_S + `OFS_ADDRESS:
			begin
				is_secure_reg = 1'b1;
				rd_val        = address_q[1];
			end
			`OFS_BANK_S + `OFS_SYND_FIRST:
			begin
				is_secure_reg = 1'b1;
				rd_val        = synd0_q[1];
			end
			`OFS_BANK_S + `OFS_SYND_SECOND:
			begin
				is_secure_reg = 1'b1;
				rd_val        = synd1_q[1];
			end
			default:                           mapped = 1'b0;
		endcase
		// Without a Secure side the Secure registers simply do not exist
		if (!SEC_EXT && is_secure_reg)
		begin
			mapped = 1'b0;
		end
	end

	// Unmapped, Secure-only and unprivileged accesses all fall here
	assign bad_access = ~mapped
		| (is_secure_reg & ~sec_acc)
		| (secure_only_global_space & ~sec_acc)
		| (PRIV_ONLY & ~pprot[0]);

	// Secure resources and the Secure-only global space log to the Secure copy
	assign cfg_bank = SEC_EXT & (sec_acc | is_secure_reg | secure_only_global_space);

	always_comb
	begin
		cfg_synd0                                 = `RESET_ZERO;
		cfg_synd0[3]                              = ~sec_acc;
		cfg_synd0[2]                              = 1'b0;
		cfg_synd0[1]                              = pwrite;
		cfg_synd0[0]                              = 1'b0;
	end

	always_comb
	begin
		cfg_ev    = 2'b00;
		clr_sel   = 2'b00;
		ctrl_wr   = 2'b00;
		sctrl1_wr = 1'b0;
		if (access && bad_access && CAF_MODE)
		begin
			cfg_ev[cfg_bank] = 1'b1;
		end
		if (access && pwrite && !bad_access)
		begin
			case (paddr)
				`OFS_CTRL_NS:                 ctrl_wr[0] = 1'b1;
				`OFS_CTRL_S:                  ctrl_wr[1] = 1'b1;
				`OFS_SCTRL1:                  sctrl1_wr  = 1'b1;
				`OFS_BANK_NS + `OFS_STATUS:   clr_sel[0] = 1'b1;
				`OFS_BANK_S + `OFS_STATUS:    clr_sel[1] = 1'b1;
				default:                      clr_sel    = 2'b00;
			endcase
		end
	end

	// ****************************************************************
	// APB answer, zero wait states
	// ****************************************************************
	// Read data and error are prepared in the setup cycle so both leave flip-flops
	assign pready  = 1'b1;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prdata_reg  <= `RESET_ZERO;
			pslverr_reg <= 1'b0;
		end
		else if (setup)
		begin
			prdata_reg  <= (bad_access || pwrite) ? `RESET_ZERO : rd_val;
			pslverr_reg <= bad_access & CAF_MODE
				& ctrl_q[cfg_bank][`BIT_CONFIG_FAULT_ABORT_ENABLE];
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sctrl1_reg <= `RESET_ZERO;
		end
		else if (sctrl1_wr)
		begin
			sctrl1_reg <= pwdata & `SCTRL1_MASK;
		end
	end

	// ****************************************************************
	// Client transaction checks
	// ****************************************************************
	// Untranslated operations arrive here with their stream mapping outcome
	assign fetch_fault = client_txn.valid & secure_fetch_check_enable & client_txn.secure
		& client_txn.instr & client_txn.ns_exit;
	assign cli_fault   = client_txn.valid
		& (client_txn.kind != fault_recorder_pkg::FK_NONE);
	// A fetch fault with a context bank belongs to that bank, not here
	assign cli_global  = cli_fault | (fetch_fault & ~client_txn.ctx_assoc);
	assign cli_bank    = SEC_EXT & (fetch_fault | client_txn.secure);

	always_comb
	begin
		cli_mask = `RESET_ZERO;
		case (client_txn.kind)
			fault_recorder_pkg::FK_INVALID_CTX: cli_mask[`BIT_INVALID_CTX] = 1'b1;
			fault_recorder_pkg::FK_UNID_STREAM: cli_mask[`BIT_UNID_STREAM] = 1'b1;
			fault_recorder_pkg::FK_MATCH_CONFL: cli_mask[`BIT_MATCH_CONFL] = 1'b1;
			fault_recorder_pkg::FK_UNIMPL_CB:   cli_mask[`BIT_UNIMPL_CB]   = 1'b1;
			fault_recorder_pkg::FK_UNIMPL_IRQ:  cli_mask[`BIT_UNIMPL_IRQ]  = 1'b1;
			fault_recorder_pkg::FK_EXTERNAL:    cli_mask[`BIT_EXTERNAL]    = 1'b1;
			default:                            cli_mask                   = `RESET_ZERO;
		endcase
		// A fetch fault owned by a context bank must not mark the global copy
		if (fetch_fault && !client_txn.ctx_assoc)
		begin
			cli_mask[`BIT_PERMISSION] = 1'b1;
		end
	end

	always_comb
	begin
		cli_synd0    = `RESET_ZERO;
		cli_synd0[3] = ~client_txn.secure;
		cli_synd0[2] = client_txn.instr;
		cli_synd0[1] = client_txn.write;
		// Nested only means something for the context selection faults
		cli_synd0[0] = client_txn.nested
			& ((client_txn.kind == fault_recorder_pkg::FK_INVALID_CTX)
			| (client_txn.kind == fault_recorder_pkg::FK_UNIMPL_CB)
			| (client_txn.kind == fault_recorder_pkg::FK_UNIMPL_IRQ));
	end

	always_comb
	begin
		cli_ev           = 2'b00;
		cli_ev[cli_bank] = cli_global;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			resp_reg    <= '0;
			cb_perm_reg <= 1'b0;
		end
		else
		begin
			resp_reg.done          <= cli_global;
			resp_reg.abort         <= cli_global
				& ctrl_q[cli_bank][`BIT_GLOBAL_FAULT_ABORT_ENABLE];
			resp_reg.write_dropped <= cli_global & client_txn.write;
			resp_reg.rdata         <= `RESET_ZERO;
			cb_perm_reg            <= fetch_fault & client_txn.ctx_assoc;
		end
	end

	assign client_resp   = resp_reg;
	assign cb_perm_fault = cb_perm_reg;

	// ****************************************************************
	// Banked status, address, syndrome and control
	// ****************************************************************
	genvar b;
	generate
		for (b = 0; b < 2; b = b + 1)
		begin : g_bank
			logic [31:0] status_reg;
			logic [31:0] address_reg;
			logic [31:0] synd0_reg;
			logic [31:0] synd1_reg;
			logic [31:0] ctrl_reg;
			logic [31:0] status_next;
			logic [31:0] address_next;
			logic [31:0] synd0_next;
			logic [31:0] synd1_next;
			logic        busy;

			always_comb
			begin
				status_next  = status_reg;
				address_next = address_reg;
				synd0_next   = synd0_reg;
				synd1_next   = synd1_reg;
				busy         = 1'b0;
				// Clear first so a fault in the same cycle is kept
				if (clr_sel[b])
				begin
					status_next = status_reg & ~(pwdata & `STATUS_MASK);
				end
				busy = (status_next != `RESET_ZERO);
				if (cfg_ev[b])
				begin
					if (busy)
					begin
						status_next[`BIT_MULTI] = 1'b1;
					end
					else
					begin
						status_next[`BIT_CAF] = 1'b1;
						address_next          = {20'h00000, paddr};
						synd0_next            = cfg_synd0;
						synd1_next            = `RESET_ZERO;
					end
					busy = 1'b1;
				end
				// Config fault wins the full record when both land together
				if (cli_ev[b])
				begin
					if (busy)
					begin
						status_next[`BIT_MULTI] = 1'b1;
					end
					else
					begin
						status_next = status_next | cli_mask;
						if (client_txn.kind != fault_recorder_pkg::FK_EXTERNAL || fetch_fault)
						begin
							address_next = client_txn.addr;
							synd0_next   = cli_synd0;
							synd1_next   = {16'h0000, client_txn.stream_id};
						end
						// external faults that are not fetch faults leave address and syndromes alone
					end
				end
			end

			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					status_reg  <= `RESET_ZERO;
					address_reg <= `RESET_ZERO;
					synd0_reg   <= `RESET_ZERO;
					synd1_reg   <= `RESET_ZERO;
				end
				else
				begin
					status_reg  <= status_next;
					address_reg <= address_next;
					synd0_reg   <= synd0_next;
					synd1_reg   <= synd1_next;
				end
			end

			always_ff @(posedge clk)
			begin
				if (sys_rst)
				begin
					ctrl_reg <= `RESET_ZERO;
				end
				else if (ctrl_wr[b])
				begin
					ctrl_reg <= pwdata & `CTRL_MASK;
				end
			end

			assign status_q[b]  = status_reg;
			assign address_q[b] = address_reg;
			assign synd0_q[b]   = synd0_reg;
			assign synd1_q[b]   = synd1_reg;
			assign ctrl_q[b]    = ctrl_reg;
		end
	endgenerate

	// ****************************************************************
	// Interrupt levels
	// ****************************************************************
	// A multiple flag steers to the general line even when it came from a
	// config access fault, so software sees one line for any pile-up
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			irq_reg <= '0;
		end
		else
		begin
			irq_reg.nonsecure_config_fault_irq <= status_q[0][`BIT_CAF]
				& ~status_q[0][`BIT_MULTI] & ctrl_q[0][`BIT_CONFIG_FAULT_IRQ_ENABLE];
			irq_reg.nonsecure_global_fault_irq <= ((status_q[0] & ~(32'h1 << `BIT_CAF))
				!= `RESET_ZERO) & ctrl_q[0][`BIT_GLOBAL_FAULT_IRQ_ENABLE];
			irq_reg.secure_config_fault_irq    <= SEC_EXT & status_q[1][`BIT_CAF]
				& ~status_q[1][`BIT_MULTI] & ctrl_q[1][`BIT_CONFIG_FAULT_IRQ_ENABLE];
			irq_reg.secure_global_fault_irq    <= SEC_EXT
				& ((status_q[1] & ~(32'h1 << `BIT_CAF)) != `RESET_ZERO)
				& ctrl_q[1][`BIT_GLOBAL_FAULT_IRQ_ENABLE];
		end
	end

	assign irq = irq_reg;
endmodule

// *** tb/global_fault_recorder_monitor.sv ***
// Port-level assertion checker for the global fault recorder
`timescale 1ns/1ns
module fault_recorder_monitor
(
	input wire logic                              clk,
	input wire logic                              sys_rst,
	input wire logic                              psel,
	input wire logic                              penable,
	input wire logic                              pwrite,
	input wire logic [11:0]                       paddr,
	input wire logic [2:0]                        pprot,
	input wire logic [31:0]                       prdata,
	input wire logic                              pslverr,
	input wire fault_recorder_pkg::client_txn_t   client_txn,
	input wire fault_recorder_pkg::client_resp_t  client_resp,
	input wire logic                              cb_perm_fault,
	input wire fault_recorder_pkg::irq_t          irq
);
	logic acc;
	assign acc = psel & penable;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ********
	// Client side
	// ********
	sequence s_client_fault;
		client_txn.valid && client_txn.kind != fault_recorder_pkg::FK_NONE;
	endsequence
	sequence s_zero_answer;
		client_resp.done && client_resp.rdata == 32'h0;
	endsequence
	property p_fault_answered;
		s_client_fault |=> s_zero_answer;
	endproperty
	a_fault_answered: assert property (p_fault_answered)
		else $error("faulting client txn not terminated");
	property p_no_stray_done;
		!client_txn.valid |=> !client_resp.done;
	endproperty
	a_no_stray_done: assert property (p_no_stray_done)
		else $error("answer without a txn");
	property p_write_dropped;
		client_resp.done |-> client_resp.write_dropped == $past(client_txn.write);
	endproperty
	a_write_dropped: assert property (p_write_dropped)
		else $error("write drop flag wrong");
	property p_ctx_no_done;
		client_txn.valid && client_txn.kind == fault_recorder_pkg::FK_NONE
			&& client_txn.ctx_assoc |=> !client_resp.done;
	endproperty
	a_ctx_no_done: assert property (p_ctx_no_done)
		else $error("context fault answered globally");
	property p_cb_cause;
		cb_perm_fault |-> $past(client_txn.valid && client_txn.secure
			&& client_txn.ns_exit && client_txn.ctx_assoc);
	endproperty
	a_cb_cause: assert property (p_cb_cause)
		else $error("context permission fault without cause");

	// ********
	// Config side and interrupts
	// ********
	property p_unmapped_raz;
		acc && !pwrite && paddr >= 12'h030 |-> prdata == 32'h0;
	endproperty
	a_unmapped_raz: assert property (p_unmapped_raz)
		else $error("unmapped read not zero");
	property p_good_no_err;
		acc && !pprot[1] && paddr[11:6] == 6'h0 && paddr[5:4] != 2'b11
			&& paddr[5:2] != 4'h3 && paddr[1:0] == 2'b00 |-> !pslverr;
	endproperty
	a_good_no_err: assert property (p_good_no_err)
		else $error("error on a legal secure access");
	property p_ctrl_raz_bits;
		acc && !pwrite && paddr == 12'h000 |-> (prdata & 32'hffff_ffc9) == 32'h0;
	endproperty
	a_ctrl_raz_bits: assert property (p_ctrl_raz_bits)
		else $error("unimplemented control bits not zero");
	property p_cfg_irq_cause;
		$rose(irq.nonsecure_config_fault_irq) || $rose(irq.secure_config_fault_irq)
			|-> $past(acc, 2);
	endproperty
	a_cfg_irq_cause: assert property (p_cfg_irq_cause)
		else $error("config irq rose without access");
	property p_glb_irq_cause;
		$rose(irq.nonsecure_global_fault_irq) |-> $past(client_resp.done) || $past(acc, 2);
	endproperty
	a_glb_irq_cause: assert property (p_glb_irq_cause)
		else $error("global irq rose without fault");
	// General lines only ever gain status bits from faults, so only a write drops them
	property p_irq_level;
		($past(irq) & ~irq & 4'b0101) != 4'h0 |-> $past(acc && pwrite, 2);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("global irq fell without software write");
	// Config lines also drop when a later fault sets the multiple flag
	property p_cfg_irq_fall;
		($past(irq) & ~irq & 4'b1010) != 4'h0 |-> $past(acc, 2) || $past(client_resp.done);
	endproperty
	a_cfg_irq_fall: assert property (p_cfg_irq_fall)
		else $error("config irq fell without write or new fault");
endmodule

bind global_fault_recorder fault_recorder_monitor u_mon
(
	.clk,
	.sys_rst,
	.psel,
	.penable,
	.pwrite,
	.paddr,
	.pprot,
	.prdata,
	.pslverr,
	.client_txn,
	.client_resp,
	.cb_perm_fault,
	.irq
);

// *** tb/client_master_model.sv ***
// Client master model: issues one-cycle transactions and records answers
`timescale 1ns/1ns
module client_master_model
(
	input  wire logic                             clk,
	output fault_recorder_pkg::client_txn_t       client_txn,
	input  wire fault_recorder_pkg::client_resp_t client_resp
);
	fault_recorder_pkg::client_resp_t last_resp;
	int                               done_cnt;

	initial
	begin
		client_txn = '0;
		last_resp = '0;
		done_cnt = 0;
	end

	// Answers stand one cycle only, so every edge is looked at
	always @(posedge clk)
		if (client_resp.done === 1'b1)
		begin
			last_resp <= client_resp;
			done_cnt <= done_cnt + 1;
		end

	task automatic send(input fault_recorder_pkg::client_txn_t txn);
		fault_recorder_pkg::client_txn_t idle;
		idle = fault_recorder_pkg::client_txn_t'(~txn);
		idle.valid = 1'b0;
		@(posedge clk);
		client_txn <= txn;
		@(posedge clk);
		// Released fields show the inverse so stale values cannot pass
		client_txn <= idle;
	endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the global fault recorder
`timescale 1ns/1ns
module tb;
	typedef struct
	{
		fault_recorder_pkg::fault_kind_t kind;
		logic                            sec;
		logic                            nest;
		logic                            wr;
		int                              bitn;
	} row_t;

	localparam logic [2:0] prot_s  = 3'b001;
	localparam logic [2:0] prot_ns = 3'b011;

	logic                             clk;
	logic                             sys_rst;
	logic                             psel;
	logic                             penable;
	logic                             pwrite;
	logic [11:0]                      paddr;
	logic [31:0]                      pwdata;
	logic [2:0]                       pprot;
	logic                             pready;
	logic [31:0]                      prdata;
	logic                             pslverr;
	logic                             cb_perm_fault;
	fault_recorder_pkg::client_txn_t  client_txn;
	fault_recorder_pkg::client_resp_t client_resp;
	fault_recorder_pkg::irq_t         irq;
	fault_recorder_pkg::client_txn_t  t;
	logic [31:0]                      rd;
	logic                             err;
	logic [11:0]                      b;
	int                               n;
	int                               m;
	int                               fails = 0;
	int                               checked = 0;
	int                               cycles = 0;
	int                               cb_cnt = 0;
	row_t                             rows [6];

	global_fault_recorder DUT
	(
		.clk,
		.sys_rst,
		.psel,
		.penable,
		.pwrite,
		.paddr,
		.pwdata,
		.pprot,
		.pready,
		.prdata,
		.pslverr,
		.client_txn,
		.client_resp,
		.cb_perm_fault,
		.irq
	);

	client_master_model u_cli
	(
		.clk,
		.client_txn,
		.client_resp
	);

	initial
		clk = 1'b0;
	always #50 clk = ~clk;

	// Whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cb_perm_fault === 1'b1)
			cb_cnt++;
		if (cycles == 4000)
		begin
			fails++;
			stop_test();
		end
	end

	// ********
	// Tasks
	// ********
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask

	task automatic stop_test();
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [2:0] p);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pprot <= p;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, prot_s);
		chk($sformatf("reg %h", a), rd, e);
	endtask

	task automatic clear();
		apb(1'b1, 12'h010, 32'hffff_ffff, prot_s);
		apb(1'b1, 12'h020, 32'hffff_ffff, prot_s);
	endtask

	task automatic prep(input fault_recorder_pkg::fault_kind_t k, input logic s,
		input logic [31:0] a);
		t = '0;
		t.valid = 1'b1;
		t.kind = k;
		t.secure = s;
		t.addr = a;
		t.stream_id = a[15:0];
	endtask

	// ********
	// Sequence
	// ********
	initial
	begin
		rows = '{
			'{fault_recorder_pkg::FK_INVALID_CTX, 1'b0, 1'b1, 1'b0, 0},
			'{fault_recorder_pkg::FK_UNID_STREAM, 1'b1, 1'b1, 1'b1, 1},
			'{fault_recorder_pkg::FK_UNIMPL_IRQ, 1'b0, 1'b1, 1'b1, 2},
			'{fault_recorder_pkg::FK_UNIMPL_CB, 1'b1, 1'b1, 1'b0, 3},
			'{fault_recorder_pkg::FK_EXTERNAL, 1'b0, 1'b0, 1'b1, 6},
			'{fault_recorder_pkg::FK_MATCH_CONFL, 1'b1, 1'b0, 1'b0, 7}};
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pprot = 3'h0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 48; a += 4)
			if (a != 12)
				rchk(12'(a), 32'h0);
		apb(1'b1, 12'h000, 32'hffff_ffff, prot_s);
		rchk(12'h000, 32'h0000_0036);
		apb(1'b1, 12'h004, 32'h0000_0036, prot_s);
		foreach (rows[i])
		begin
			clear();
			prep(rows[i].kind, rows[i].sec, 32'h4000_1000 + 32'(i * 16));
			t.nested = rows[i].nest;
			t.write = rows[i].wr;
			n = u_cli.done_cnt;
			u_cli.send(t);
			repeat (2) @(posedge clk);
			chk("done count", u_cli.done_cnt, n + 1);
			chk("abort", u_cli.last_resp.abort, 1'b1);
			chk("write dropped", u_cli.last_resp.write_dropped, t.write);
			chk("irq", irq, rows[i].sec ? 32'h1 : 32'h4);
			b = rows[i].sec ? 12'h020 : 12'h010;
			rchk(b, 32'h1 << rows[i].bitn);
			rchk(b ^ 12'h030, 32'h0);
			if (rows[i].kind != fault_recorder_pkg::FK_EXTERNAL)
			begin
				rchk(b + 12'h4, t.addr);
				rchk(b + 12'h8, {28'h0, ~t.secure, 1'b0, t.write,
					t.nested & (rows[i].bitn inside {0, 2, 3})});
				rchk(b + 12'hc, {16'h0, t.stream_id});
			end
			else
			begin
				rchk(b + 12'h4, 32'h4000_1020);
			end
		end
		clear();
		prep(fault_recorder_pkg::FK_UNID_STREAM, 1'b0, 32'h5000_0010);
		u_cli.send(t);
		prep(fault_recorder_pkg::FK_INVALID_CTX, 1'b0, 32'h5000_0020);
		u_cli.send(t);
		rchk(12'h010, 32'h8000_0002);
		rchk(12'h014, 32'h5000_0010);
		rchk(12'h01c, 32'h0000_0010);
		apb(1'b1, 12'h010, 32'h8000_0002, prot_s);
		rchk(12'h010, 32'h0);
		chk("irq", irq, 32'h0);
		// Abort enables off, interrupt enables kept
		apb(1'b1, 12'h000, 32'h0000_0024, prot_s);
		prep(fault_recorder_pkg::FK_UNIMPL_CB, 1'b0, 32'h5000_0030);
		u_cli.send(t);
		repeat (2) @(posedge clk);
		chk("abort", u_cli.last_resp.abort, 1'b0);
		clear();
		apb(1'b0, 12'h040, 32'h0, prot_ns);
		chk("read data", rd, 32'h0);
		chk("slave error", err, 1'b0);
		rchk(12'h010, 32'h0000_0020);
		rchk(12'h014, 32'h0000_0040);
		rchk(12'h018, 32'h0000_0008);
		chk("irq", irq, 32'h8);
		apb(1'b0, 12'h040, 32'h0, prot_ns);
		rchk(12'h010, 32'h8000_0020);
		chk("irq", irq, 32'h4);
		apb(1'b1, 12'h008, 32'h0000_0003, prot_ns);
		chk("slave error", err, 1'b1);
		rchk(12'h020, 32'h0000_0020);
		rchk(12'h028, 32'h0000_000a);
		rchk(12'h008, 32'h0);
		chk("irq", irq, 32'h6);
		clear();
		apb(1'b1, 12'h008, 32'h0000_0002, prot_s);
		apb(1'b0, 12'h000, 32'h0, prot_ns);
		chk("read data", rd, 32'h0);
		rchk(12'h020, 32'h0000_0020);
		rchk(12'h010, 32'h0);
		apb(1'b1, 12'h008, 32'h0000_0001, prot_s);
		clear();
		prep(fault_recorder_pkg::FK_NONE, 1'b1, 32'h5000_0040);
		t.ns_exit = 1'b1;
		t.instr = 1'b1;
		n = u_cli.done_cnt;
		m = cb_cnt;
		u_cli.send(t);
		rchk(12'h020, 32'h0000_0010);
		chk("done count", u_cli.done_cnt, n + 1);
		t.ctx_assoc = 1'b1;
		u_cli.send(t);
		repeat (2) @(posedge clk);
		chk("context fault", cb_cnt, m + 1);
		chk("done count", u_cli.done_cnt, n + 1);
		apb(1'b1, 12'h008, 32'h0, prot_s);
		t.ctx_assoc = 1'b0;
		u_cli.send(t);
		repeat (2) @(posedge clk);
		chk("done count", u_cli.done_cnt, n + 1);
		// Mid-run reset must drop every record and level
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		chk("irq", irq, 32'h0);
		rchk(12'h020, 32'h0);
		rchk(12'h004, 32'h0);
		stop_test();
	end
endmodule
